// ==== rtl/bbx_consts.svh ====
// Purpose: Constants for the byte and bit instruction executor.
// Assumes: 12-bit instruction words, 8-bit data path, 5-bit file address.
// Notes: Opcode fields are matched on the top bits of the word.
`ifndef BBX_CONSTS_SVH
`define BBX_CONSTS_SVH

// Widths
`define BBX_INSTR_W 12
`define BBX_DATA_W 8
`define BBX_ADDR_W 5
`define BBX_PORT_W 4

// Field positions
`define BBX_F_MSB 4
`define BBX_D_BIT 5
`define BBX_B_LSB 5
`define BBX_B_MSB 7

// Byte operations, match on word bits 11:6
`define BBX_OP_ADD 6'h07
`define BBX_OP_AND 6'h05
`define BBX_OP_MOV 6'h08

// Bit operations and literal AND, match on word bits 11:8
`define BBX_OP_BCLR 4'h4
`define BBX_OP_BSET 4'h5
`define BBX_OP_SKPC 4'h6
`define BBX_OP_SKPS 4'h7
`define BBX_OP_ANDL 4'he

// Whole-word and partial-word encodings
`define BBX_OP_CLR_ACC 12'h040
`define BBX_OP_DIR_LD 9'h000

// File addresses with side effects
`define BBX_ADDR_TIMER 5'h01
`define BBX_ADDR_PORT 5'h06
`define BBX_DIR_PORT 3'h6

// Reset values
`define BBX_RST_W 8'h00
`define BBX_RST_DIR 4'hf
`define BBX_RST_LATCH 4'h0

`endif

// ==== rtl/bbx_pkg.sv ====
// Purpose: Types for the byte and bit instruction executor.
// Assumes: Used together with bbx_consts.svh.
// Notes: Flags travel as one packed struct.
package bbx_pkg;

  // Arithmetic status flags
  typedef struct packed {
    logic carry;
    logic digit_carry;
    logic zero;
  } bbx_flags_t;

  // Pending file register write
  typedef struct packed {
    logic we;
    logic [4:0] addr;
    logic [7:0] data;
  } bbx_fwr_t;

  // Executor sequencing
  typedef enum logic [1:0] {
    BBX_ST_RUN = 2'b01,
    BBX_ST_SKIP = 2'b10
  } bbx_state_t;

endpackage

// ==== rtl/bbx_exec.sv ====
// Purpose: Executes byte-oriented, bit-oriented and a few literal and
//          control instructions of a small 12-bit instruction core.
// Assumes: One instruction per valid cycle; file register read data is
//          combinational from o_file_addr; i_pins is asynchronous.
// Notes: Port output latch and direction latch live here; the timer
//        and the rest of the file live outside.
`timescale 1ns/10ps
`default_nettype none
`include "bbx_consts.svh"

module bbx_exec
  import bbx_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_instr_valid,
  input wire logic [`BBX_INSTR_W-1:0] i_instr,
  input wire logic [`BBX_DATA_W-1:0] i_file_rdata,
  input wire logic i_psa_timer,
  input wire logic [`BBX_PORT_W-1:0] i_pins,
  output logic [`BBX_ADDR_W-1:0] o_file_addr,
  output logic o_file_we,
  output logic [`BBX_ADDR_W-1:0] o_file_waddr,
  output logic [`BBX_DATA_W-1:0] o_file_wdata,
  output logic [`BBX_DATA_W-1:0] o_w,
  output bbx_flags_t o_flags,
  output logic o_skip,
  output logic o_prescaler_clr,
  output logic [`BBX_PORT_W-1:0] o_pin_out,
  output logic [`BBX_PORT_W-1:0] o_pin_oe_b
);

  // Pin synchroniser stages
  logic [`BBX_PORT_W-1:0] pin_meta;
  logic [`BBX_PORT_W-1:0] pin_sync;

  // Architectural state
  logic [`BBX_DATA_W-1:0] w_reg;
  bbx_flags_t flags;
  logic [`BBX_PORT_W-1:0] dir_latch;
  logic [`BBX_PORT_W-1:0] port_latch;
  bbx_fwr_t fwr;
  bbx_state_t state;
  logic skip_pulse;
  logic psc_pulse;

  // Next values from the decoder
  logic [`BBX_DATA_W-1:0] next_w;
  bbx_flags_t next_flags;
  bbx_fwr_t next_fwr;
  logic next_skip;
  logic next_psc;
  logic next_dir_ld;

  // Decode helpers
  logic [`BBX_ADDR_W-1:0] f_addr;
  logic dest_file;
  logic [2:0] bit_sel;
  logic [`BBX_DATA_W-1:0] f_val;
  logic [`BBX_DATA_W-1:0] bit_mask;
  logic [`BBX_DATA_W:0] sum;
  logic [4:0] low_sum;
  logic exec;
  logic is_add;
  logic is_and;
  logic is_mov;
  logic is_bclr;
  logic is_bset;
  logic is_skpc;
  logic is_skps;
  logic is_andl;
  logic is_clr;
  logic is_dir;
  logic [`BBX_DATA_W-1:0] and_res;

  assign f_addr = i_instr[`BBX_F_MSB:0];
  assign dest_file = i_instr[`BBX_D_BIT];
  assign bit_sel = i_instr[`BBX_B_MSB:`BBX_B_LSB];
  assign bit_mask = 8'h01 << bit_sel;
  assign o_file_addr = f_addr;

  // A word arriving during the skip slot is the discarded one
  assign exec = i_instr_valid && (state == BBX_ST_RUN);

  // Opcode match, one line per instruction
  assign is_add = (i_instr[11:6] == `BBX_OP_ADD);
  assign is_and = (i_instr[11:6] == `BBX_OP_AND);
  assign is_mov = (i_instr[11:6] == `BBX_OP_MOV);
  assign is_bclr = (i_instr[11:8] == `BBX_OP_BCLR);
  assign is_bset = (i_instr[11:8] == `BBX_OP_BSET);
  assign is_skpc = (i_instr[11:8] == `BBX_OP_SKPC);
  assign is_skps = (i_instr[11:8] == `BBX_OP_SKPS);
  assign is_andl = (i_instr[11:8] == `BBX_OP_ANDL);
  assign is_clr = (i_instr == `BBX_OP_CLR_ACC);
  assign is_dir = (i_instr[11:3] == `BBX_OP_DIR_LD);

  // Two-stage synchroniser on the port pins
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else if (i_ce) begin
      pin_meta <= i_pins;
      pin_sync <= pin_meta;
    end
  end

  // Operand fetch: pins for the port, forwarding for a fresh write
  always_comb begin
    if (f_addr == `BBX_ADDR_PORT) begin
      f_val = {{(`BBX_DATA_W-`BBX_PORT_W){1'b0}}, pin_sync};
    end else if (fwr.we && (fwr.addr == f_addr)) begin
      f_val = fwr.data;
    end else begin
      f_val = i_file_rdata;
    end
  end

  // Sums for add; carry from bit 7, digit carry from bit 3
  assign sum = {1'b0, w_reg} + {1'b0, f_val};
  assign low_sum = {1'b0, w_reg[3:0]} + {1'b0, f_val[3:0]};

  // Register AND result
  assign and_res = w_reg & f_val;

  // Instruction decode and execute
  always_comb begin
    next_w = w_reg;
    next_flags = flags;
    next_fwr = '0;
    next_skip = 1'b0;
    next_dir_ld = 1'b0;
    next_fwr.addr = f_addr;
    if (exec) begin
      // Add, all three flags
      if (is_add) begin
        next_flags.carry = sum[`BBX_DATA_W];
        next_flags.digit_carry = low_sum[4];
        next_flags.zero = (sum[`BBX_DATA_W-1:0] == 8'h00);
        if (dest_file) begin
          next_fwr.we = 1'b1;
          next_fwr.data = sum[`BBX_DATA_W-1:0];
        end else begin
          next_w = sum[`BBX_DATA_W-1:0];
        end
      end else if (is_and) begin
        // Register AND, zero flag only
        next_flags.zero = (and_res == 8'h00);
        if (dest_file) begin
          next_fwr.we = 1'b1;
          next_fwr.data = and_res;
        end else begin
          next_w = and_res;
        end
      end else if (is_mov) begin
        // Move, zero flag only
        next_flags.zero = (f_val == 8'h00);
        if (dest_file) begin
          next_fwr.we = 1'b1;
          next_fwr.data = f_val;
        end else begin
          next_w = f_val;
        end
      end else if (is_bclr) begin
        // Bit clear, flags carried over
        next_fwr.we = 1'b1;
        next_fwr.data = f_val & ~bit_mask;
      end else if (is_bset) begin
        // Bit set, flags carried over
        next_fwr.we = 1'b1;
        next_fwr.data = f_val | bit_mask;
      end else if (is_skpc) begin
        // Skip when the tested bit is low
        next_skip = ~f_val[bit_sel];
      end else if (is_skps) begin
        // Skip when the tested bit is high
        next_skip = f_val[bit_sel];
      end else if (is_andl) begin
        // Literal AND into W
        next_w = w_reg & i_instr[7:0];
        next_flags.zero = ((w_reg & i_instr[7:0]) == 8'h00);
      end else if (is_clr) begin
        // Clear W, zero flag forced
        next_w = 8'h00;
        next_flags.zero = 1'b1;
      end else if (is_dir) begin
        // Only the port operand loads the direction latch
        next_dir_ld = (i_instr[2:0] == `BBX_DIR_PORT);
      end
    end
  end

  // A file write landing on the timer clears its prescaler when i_psa_timer is high
  assign next_psc = next_fwr.we && (f_addr == `BBX_ADDR_TIMER) &&
                    i_psa_timer;

  // Working register, one update per executed word
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      w_reg <= `BBX_RST_W;
    end else if (i_ce) begin
      w_reg <= next_w;
    end
  end

  // Status flags; bit ops and skips carry them over
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flags <= '0;
    end else if (i_ce) begin
      flags <= next_flags;
    end
  end

  // File write port, one cycle after execution
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fwr <= '0;
      psc_pulse <= 1'b0;
    end else if (i_ce) begin
      fwr <= next_fwr;
      psc_pulse <= next_psc;
    end
  end

  // Port output latch follows writes to the port address
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      port_latch <= `BBX_RST_LATCH;
    end else if (i_ce && next_fwr.we && (f_addr == `BBX_ADDR_PORT)) begin
      port_latch <= next_fwr.data[`BBX_PORT_W-1:0];
    end
  end

  // Direction latch; a one leaves its pin floating
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dir_latch <= `BBX_RST_DIR;
    end else if (i_ce && next_dir_ld) begin
      dir_latch <= w_reg[`BBX_PORT_W-1:0];
    end
  end

  // Skip pulse marks the slot whose word is dropped
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      skip_pulse <= 1'b0;
    end else if (i_ce) begin
      skip_pulse <= next_skip;
    end
  end

  // Skip sequencing: the slot lasts until the next valid word, which is dropped
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= BBX_ST_RUN;
    end else if (i_ce) begin
      case (state)
        BBX_ST_RUN: begin
          // Enter the slot on a taken test
          if (next_skip) begin
            state <= BBX_ST_SKIP;
          end
        end
        BBX_ST_SKIP: begin
          // The next word to arrive is the one dropped
          if (i_instr_valid) begin
            state <= BBX_ST_RUN;
          end
        end
        default: begin
          state <= BBX_ST_RUN;
        end
      endcase
    end
  end

  // Outputs
  assign o_file_we = fwr.we;
  assign o_file_waddr = fwr.addr;
  assign o_file_wdata = fwr.data;
  assign o_w = w_reg;
  assign o_flags = flags;
  assign o_skip = skip_pulse;
  assign o_prescaler_clr = psc_pulse;

  // Port pins; a high enable_b bit releases its pin
  assign o_pin_out = port_latch;
  assign o_pin_oe_b = dir_latch;

endmodule
`default_nettype wire

// ==== bench/bbx_exec_asserts.sv ====
// Purpose: Port checks for bbx_exec.
// Assumes: Clock enable may drop; words then wait.
// Notes: Bound to every bbx_exec.
`timescale 1ns/10ps
`default_nettype none
`include "bbx_consts.svh"
module bbx_exec_asserts
  import bbx_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_instr_valid,
  input wire logic [11:0] i_instr,
  input wire logic [7:0] i_file_rdata,
  input wire logic i_psa_timer,
  input wire logic o_file_we,
  input wire logic [4:0] o_file_waddr,
  input wire logic [7:0] o_w,
  input wire bbx_flags_t o_flags,
  input wire logic o_skip,
  input wire logic o_prescaler_clr,
  input wire logic [3:0] o_pin_oe_b
);
  logic slot_q;
  logic live;
  logic take;
  logic nofw;
  // Skip slot tracking, reads not hidden by forwarding
  assign live = o_skip | slot_q;
  assign take = i_ce & i_instr_valid & ~live;
  assign nofw = !(o_file_we && o_file_waddr == i_instr[4:0])
    && i_instr[4:0] != `BBX_ADDR_PORT;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) slot_q <= 1'b0;
    else if (i_ce) slot_q <= live & ~i_instr_valid;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  clr_acc_a: assert property (
    take && i_instr == `BBX_OP_CLR_ACC |=> o_w == 8'h00 && o_flags.zero)
    else $error("clear w wrong");
  andl_only_a: assert property (
    take && i_instr[11:8] == `BBX_OP_ANDL |=>
    o_w == ($past(o_w) & $past(i_instr[7:0])) && o_flags.zero == (o_w == 8'h00)
    && o_flags.carry == $past(o_flags.carry)) else $error("and literal wrong");
  add_w_a: assert property (
    take && nofw && i_instr[11:5] == {`BBX_OP_ADD, 1'b0} |=>
    o_w == 8'($past(o_w) + $past(i_file_rdata))) else $error("add wrong");
  skip_test_a: assert property (
    take && nofw && i_instr[11:9] == 3'b011 |=>
    o_skip == $past(i_file_rdata[i_instr[7:5]] == i_instr[8]))
    else $error("skip decision wrong");
  skip_drop_a: assert property (
    live && i_ce && i_instr_valid |=> !o_file_we && $stable(o_w)
    && $stable(o_flags))
    else $error("discarded word acted");
  bit_flags_a: assert property (
    take && i_instr[11:9] == 3'b010 |=> $stable(o_flags) && o_file_we
    && o_file_waddr == $past(i_instr[4:0])) else $error("bit op wrong");
  dir_load_a: assert property (
    take && i_instr == 12'h006 |=> o_pin_oe_b == $past(o_w[3:0]))
    else $error("direction load wrong");
  pclr_a: assert property (
    o_prescaler_clr == (o_file_we && o_file_waddr == `BBX_ADDR_TIMER
    && $past(i_psa_timer))) else $error("prescaler clear wrong");
  // Main scenarios reached
  cover property (take && i_instr[11:9] == 3'b011 ##1 o_skip);
  cover property (o_prescaler_clr);
  cover property (take && i_instr == 12'h006);
  cover property (live && i_ce && i_instr_valid);
endmodule
bind bbx_exec bbx_exec_asserts u_bbx_exec_asserts (.i_clk(i_clk),
  .i_rst_b(i_rst_b), .i_ce(i_ce), .i_instr_valid(i_instr_valid),
  .i_instr(i_instr), .i_file_rdata(i_file_rdata),
  .i_psa_timer(i_psa_timer), .o_file_we(o_file_we),
  .o_file_waddr(o_file_waddr), .o_w(o_w), .o_flags(o_flags),
  .o_skip(o_skip), .o_prescaler_clr(o_prescaler_clr),
  .o_pin_oe_b(o_pin_oe_b));
`default_nettype wire

// ==== bench/bbx_exec_bench.sv ====
// Purpose: Self-checking bench for bbx_exec.
// Assumes: Mostly a word every other cycle; one hold and one burst.
// Notes: Bench model tracks W, flags, file and direction latch.
`timescale 1ns/10ps
`default_nettype none
`include "bbx_consts.svh"
module bbx_exec_bench
  import bbx_pkg::*;
();
  logic i_clk, i_rst_b, i_ce, i_instr_valid, i_psa_timer, o_file_we;
  logic o_skip, o_prescaler_clr, pend;
  logic [11:0] i_instr, ins;
  logic [7:0] i_file_rdata, o_file_wdata, o_w, w;
  logic [4:0] o_file_addr, o_file_waddr;
  logic [3:0] i_pins, o_pin_out, o_pin_oe_b, oe, po;
  logic [7:0] m [32];
  bbx_flags_t o_flags, fl;
  int err_count, checks, cyc, sd, k;
  localparam logic [11:0] ops [9] = '{12'h1c0, 12'h140, 12'h200, 12'h400,
    12'h500, 12'h600, 12'h700, 12'he00, 12'h040};
  localparam logic [11:0] msk [9] = '{12'h020, 12'h020, 12'h020, 12'h0e0,
    12'h0e0, 12'h0e0, 12'h0e0, 12'h0ff, 12'h000};
  bbx_exec u_bbx_exec (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
    .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_pins(i_pins),
    .i_file_rdata(i_file_rdata), .i_psa_timer(i_psa_timer), .o_w(o_w),
    .o_file_addr(o_file_addr), .o_file_we(o_file_we), .o_skip(o_skip),
    .o_file_waddr(o_file_waddr), .o_file_wdata(o_file_wdata),
    .o_flags(o_flags), .o_prescaler_clr(o_prescaler_clr),
    .o_pin_out(o_pin_out), .o_pin_oe_b(o_pin_oe_b));
  // Clock and hang guard
  always #2 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  // Prescaler clear expected for a file write to the timer
  function automatic logic exp_pclr(input logic we, input logic [4:0] a,
    input logic psa);
    return we && a == `BBX_ADDR_TIMER && psa;
  endfunction
  // Issue one word, predict and compare the result
  task automatic run(input logic [11:0] ins);
    logic [7:0] f, r, ew;
    logic [4:0] s;
    logic [8:0] t;
    logic we, sk;
    bbx_flags_t ef;
    f = ins[4:0] == 5'h06 ? {4'h0, i_pins} : m[ins[4:0]];
    ew = w;
    ef = fl;
    we = 1'b0;
    sk = 1'b0;
    r = f;
    if (!pend) begin
      if (ins[11:6] == `BBX_OP_ADD || ins[11:6] == `BBX_OP_AND
          || ins[11:6] == `BBX_OP_MOV) begin
        s = {1'b0, w[3:0]} + {1'b0, f[3:0]};
        t = {1'b0, w} + {1'b0, f};
        if (ins[11:6] == `BBX_OP_ADD) begin
          r = t[7:0];
          ef.carry = t[8];
          ef.digit_carry = s[4];
        end
        if (ins[11:6] == `BBX_OP_AND) r = w & f;
        ef.zero = r == 8'h00;
        we = ins[5];
        if (!ins[5]) ew = r;
      end
      if (ins[11:9] == 3'b010) begin
        we = 1'b1;
        r[ins[7:5]] = ins[8];
      end
      if (ins[11:9] == 3'b011) sk = f[ins[7:5]] == ins[8];
      if (ins[11:8] == `BBX_OP_ANDL) begin
        ew = w & ins[7:0];
        ef.zero = ew == 8'h00;
      end
      if (ins == `BBX_OP_CLR_ACC) begin
        ew = 8'h00;
        ef.zero = 1'b1;
      end
      if (ins == 12'h006) oe = w[3:0];
      if (we && ins[4:0] == `BBX_ADDR_PORT) po = r[3:0];
    end
    @(posedge i_clk);
    i_instr <= ins;
    i_instr_valid <= 1'b1;
    i_file_rdata <= m[ins[4:0]];
    @(posedge i_clk);
    i_instr_valid <= 1'b0;
    #1;
    chk("addr", {3'h0, o_file_addr}, {3'h0, ins[4:0]});
    chk("w", o_w, ew);
    chk("flags", {5'h0, o_flags}, {5'h0, ef});
    chk("we", {7'h0, o_file_we}, {7'h0, we});
    if (we) chk("wdata", o_file_wdata, r);
    if (we) chk("waddr", {3'h0, o_file_waddr}, {3'h0, ins[4:0]});
    chk("skip", {7'h0, o_skip}, {7'h0, sk});
    chk("pclr", {7'h0, o_prescaler_clr},
      {7'h0, exp_pclr(we, ins[4:0], i_psa_timer)});
    chk("oe", {4'h0, o_pin_oe_b}, {4'h0, oe});
    chk("pout", {4'h0, o_pin_out}, {4'h0, po});
    if (we) m[ins[4:0]] = r;
    w = ew;
    fl = ef;
    pend = sk;
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Reset, corner cases, then random words
  initial begin
    i_clk = 1'b0;
    i_rst_b = 1'b0;
    i_ce = 1'b1;
    i_instr_valid = 1'b0;
    i_instr = 12'h000;
    i_file_rdata = 8'h00;
    i_psa_timer = 1'b0;
    i_pins = 4'h0;
    w = 8'h00;
    fl = '0;
    pend = 1'b0;
    oe = 4'hf;
    po = 4'h0;
    sd = $urandom(25);
    for (k = 0; k < 32; k++) m[k] = 8'($urandom);
    m[6] = 8'hff;
    m[8] = 8'h3c;
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1'b1;
    i_pins <= 4'h5;
    run(12'h040);
    run(12'h208);
    run(12'h006);
    run(12'h005);
    run(12'h226);
    // Latch holds 1 on bit 0 but the pin now reads low
    i_pins <= 4'h0;
    repeat (2) @(posedge i_clk);
    run(12'h506);
    i_psa_timer <= 1'b1;
    run(12'h5a1);
    run(12'h1c1);
    i_psa_timer <= 1'b0;
    run(12'h4a1);
    run(12'h449);
    run(12'h649);
    run(12'h040);
    run(12'h208);
    // Clock enable low freezes a pending clear of W
    @(posedge i_clk);
    i_ce <= 1'b0;
    i_instr <= `BBX_OP_CLR_ACC;
    i_instr_valid <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_ce <= 1'b1;
    i_instr_valid <= 1'b0;
    #1;
    chk("hold", o_w, w);
    i_pins <= 4'($urandom);
    // Back to back bit sets, second reads the forwarded write
    @(posedge i_clk);
    i_instr <= 12'h50a;
    i_instr_valid <= 1'b1;
    i_file_rdata <= m[10];
    @(posedge i_clk);
    i_instr <= 12'h52a;
    i_file_rdata <= m[10];
    @(posedge i_clk);
    i_instr_valid <= 1'b0;
    #1;
    chk("fwd", o_file_wdata, m[10] | 8'h03);
    m[10] = m[10] | 8'h03;
    for (int n = 0; n < 300; n++) begin
      k = $urandom % 9;
      ins = ops[k] | (msk[k] & 12'($urandom));
      if (k < 7) ins[4:0] = 5'(8 + $urandom % 24);
      if (k < 7 && $urandom % 6 == 0) ins[4:0] = `BBX_ADDR_PORT;
      run(ins);
    end
    finish_test();
  end
endmodule
`default_nettype wire
